// file: strap_boot_config_select.v
// strap decoder and boot source selector, top level
// Function
// - capture straps into status on reset release
// - rom variant: two i2c addresses, spi slave
// - rom variant code 11: eeprom boot master
// - eeprom variant: three i2c addresses, spi
// - config straps pick one of eight configs
// - test plus 011 skips auto configuration
// - slave address register writable, strap default
// - own select drives eeprom only while booting from external eeprom
// - buffer select 10 enables clock input
// - buffer select 01 enables crystal driver
// - reference doubler after crystal or clock
// - pll input doubler enable doubles input
`include "strap_boot_config_select_regs.vh"
module strap_boot_config_select #(
	parameter INTERNAL_EEPROM = 0
) (
	input wire sys_clk,
	input wire reset,
	input wire reset_in_n,
	input wire test_strap,
	input wire [1:0] interface_strap,
	input wire [2:0] config_select_strap,
	input wire slave_addr_wr,
	input wire [6:0] slave_addr_wdata,
	input wire boot_done,
	input wire boot_cs_req,
	input wire [1:0] ref_buffer_select,
	input wire ref_doubler_en,
	input wire pll_input_doubler_en,
	output reg [5:0] strap_status_reg,
	output reg [3:0] interface_mode,
	output reg [1:0] boot_source,
	output reg [2:0] config_index,
	output reg autoconfig_en,
	output reg boot_start,
	output reg boot_active,
	output reg [6:0] slave_addr_reg,
	output reg chip_select_n,
	output reg chip_select_oe_n,
	output reg ref_clk_in_en,
	output reg xtal_driver_en,
	output reg ref_doubler_active,
	output reg pll_doubler_active,
	output reg doubler_conflict
);

// ----------------------------------------
// states
// ----------------------------------------
localparam ST_RESET = 4'h1;
localparam ST_LATCH = 4'h2;
localparam ST_BOOT = 4'h4;
localparam ST_RUN = 4'h8;

reg [3:0] state;
reg [3:0] next_state;
wire [5:0] strap_sync_bus;
wire rst_pin_s;
reg rst_pin_d;
wire rst_rise;

// ----------------------------------------
// synchronise pins
// ----------------------------------------
strap_sync #(
	.WIDTH(1)
) u_sync_rst (
	.sys_clk(sys_clk),
	.reset(reset),
	.din(reset_in_n),
	.dout(rst_pin_s)
);

strap_sync #(
	.WIDTH(`STATUS_W)
) u_sync_strap (
	.sys_clk(sys_clk),
	.reset(reset),
	.din({test_strap, interface_strap, config_select_strap}),
	.dout(strap_sync_bus)
);

always @(posedge sys_clk or posedge reset) begin
	if (reset)
		rst_pin_d <= 1'b0;
	else
		rst_pin_d <= rst_pin_s;
end

assign rst_rise = rst_pin_s && !rst_pin_d;

// ----------------------------------------
// strap decode
// ----------------------------------------
reg [3:0] next_mode;
reg [1:0] next_boot;
reg [6:0] next_addr;
reg next_autocfg;
wire [1:0] if_code;
wire [2:0] cfg_code;
wire skip_cfg;

assign if_code = strap_sync_bus[`ST_IF_HI:`ST_IF_LO];
assign cfg_code = strap_sync_bus[`ST_CFG_HI:`ST_CFG_LO];
assign skip_cfg = strap_sync_bus[`ST_TEST] &&
	(cfg_code == `CFG_NO_AUTOCONFIG);

always @* begin
	next_mode = `MODE_NONE;
	next_boot = `BOOT_NONE;
	next_addr = `ADDR_A0;
	if (INTERNAL_EEPROM != 0) begin
		next_boot = `BOOT_INT_EEPROM;
		case (if_code)
		`IF_CODE_0: begin
			next_mode = `MODE_I2C;
			next_addr = `ADDR_A0;
		end
		`IF_CODE_1: begin
			next_mode = `MODE_I2C;
			next_addr = `ADDR_A1;
		end
		`IF_CODE_2: begin
			next_mode = `MODE_I2C;
			next_addr = `ADDR_A2;
		end
		default: begin
			next_mode = `MODE_SPI_SLAVE;
		end
		endcase
	end else begin
		case (if_code)
		`IF_CODE_0: begin
			next_mode = `MODE_I2C;
			next_addr = `ADDR_A0;
			next_boot = `BOOT_ROM;
		end
		`IF_CODE_1: begin
			next_mode = `MODE_I2C;
			next_addr = `ADDR_A1;
			next_boot = `BOOT_ROM;
		end
		`IF_CODE_2: begin
			next_mode = `MODE_SPI_SLAVE;
			next_boot = `BOOT_ROM;
		end
		default: begin
			next_mode = `MODE_SPI_MASTER;
			next_boot = `BOOT_EXT_EEPROM;
		end
		endcase
	end
	next_autocfg = !skip_cfg;
	if (skip_cfg) begin
		next_boot = `BOOT_NONE;
		if (next_mode == `MODE_SPI_MASTER)
			next_mode = `MODE_SPI_SLAVE;
	end
end

// ----------------------------------------
// boot sequencer
// ----------------------------------------
always @* begin
	next_state = state;
	case (state)
	ST_RESET: begin
		if (rst_rise)
			next_state = ST_LATCH;
	end
	ST_LATCH: begin
		next_state = autoconfig_en ? ST_BOOT : ST_RUN;
	end
	ST_BOOT: begin
		if (boot_done)
			next_state = ST_RUN;
	end
	ST_RUN: begin
		next_state = ST_RUN;
	end
	default: begin
		next_state = ST_RESET;
	end
	endcase
	if (!rst_pin_s)
		next_state = ST_RESET;
end

// ----------------------------------------
// state register
// ----------------------------------------
wire latch_now;
reg [6:0] next_slave_addr;
reg next_cs_n;
reg next_cs_oe_n;

assign latch_now = (state == ST_RESET) && rst_rise;

always @(posedge sys_clk or posedge reset) begin
	if (reset)
		state <= ST_RESET;
	else
		state <= next_state;
end

// ----------------------------------------
// strap latch, held until next reset, except that spi master mode drops to spi slave in run
// ----------------------------------------
always @(posedge sys_clk or posedge reset) begin
	if (reset) begin
		strap_status_reg <= `STATUS_RESET;
		interface_mode <= `MODE_NONE;
		boot_source <= `BOOT_NONE;
		config_index <= `CFG_RESET;
		autoconfig_en <= 1'b0;
	end else if (latch_now) begin
		strap_status_reg <= strap_sync_bus;
		interface_mode <= next_mode;
		boot_source <= next_boot;
		config_index <= cfg_code;
		autoconfig_en <= next_autocfg;
	end else if (state == ST_RUN &&
		interface_mode == `MODE_SPI_MASTER) begin
		// master only while booting, then slave
		interface_mode <= `MODE_SPI_SLAVE;
	end
end

// ----------------------------------------
// slave address register
// ----------------------------------------
always @* begin
	next_slave_addr = slave_addr_reg;
	if (latch_now)
		next_slave_addr = next_addr;
	else if (slave_addr_wr)
		next_slave_addr = slave_addr_wdata;
end

always @(posedge sys_clk or posedge reset) begin
	if (reset)
		slave_addr_reg <= `ADDR_A0;
	else
		slave_addr_reg <= next_slave_addr;
end

// ----------------------------------------
// boot strobes
// ----------------------------------------
always @(posedge sys_clk or posedge reset) begin
	if (reset) begin
		boot_start <= 1'b0;
		boot_active <= 1'b0;
	end else begin
		boot_start <= (state == ST_LATCH) && autoconfig_en;
		boot_active <= (next_state == ST_BOOT);
	end
end

// ----------------------------------------
// eeprom select
// ----------------------------------------
always @* begin
	next_cs_oe_n = 1'b1;
	next_cs_n = 1'b1;
	// own select drives eeprom only while booting from it
	if (next_state == ST_BOOT &&
		boot_source == `BOOT_EXT_EEPROM) begin
		next_cs_oe_n = 1'b0;
		next_cs_n = !boot_cs_req;
	end
end

always @(posedge sys_clk or posedge reset) begin
	if (reset) begin
		chip_select_n <= 1'b1;
		chip_select_oe_n <= 1'b1;
	end else begin
		chip_select_n <= next_cs_n;
		chip_select_oe_n <= next_cs_oe_n;
	end
end

// ----------------------------------------
// reference clock configuration
// ----------------------------------------
ref_clock_control u_ref (
	.sys_clk(sys_clk),
	.reset(reset),
	.ref_buffer_select(ref_buffer_select),
	.ref_doubler_en(ref_doubler_en),
	.pll_input_doubler_en(pll_input_doubler_en),
	.ref_clk_in_en(ref_clk_in_en),
	.xtal_driver_en(xtal_driver_en),
	.ref_doubler_active(ref_doubler_active),
	.pll_doubler_active(pll_doubler_active),
	.doubler_conflict(doubler_conflict)
);

endmodule

// file: strap_boot_config_select_regs.vh
// constants for the strap decoder and boot source selector
`ifndef STRAP_BOOT_CONFIG_SELECT_REGS_VH
`define STRAP_BOOT_CONFIG_SELECT_REGS_VH

// ----------------------------------------
// interface strap codes
// ----------------------------------------
`define IF_CODE_0 2'h0
`define IF_CODE_1 2'h1
`define IF_CODE_2 2'h2
`define IF_CODE_3 2'h3

// ----------------------------------------
// interface modes (one-hot)
// ----------------------------------------
`define MODE_W 4
`define MODE_I2C 4'h1
`define MODE_SPI_SLAVE 4'h2
`define MODE_SPI_MASTER 4'h4
`define MODE_NONE 4'h0

// ----------------------------------------
// boot sources
// ----------------------------------------
`define BOOT_W 2
`define BOOT_ROM 2'h0
`define BOOT_EXT_EEPROM 2'h1
`define BOOT_INT_EEPROM 2'h2
`define BOOT_NONE 2'h3

// ----------------------------------------
// slave addresses
// ----------------------------------------
`define ADDR_W 7
`define ADDR_A0 7'h74
`define ADDR_A1 7'h75
`define ADDR_A2 7'h76

// ----------------------------------------
// strap status layout
// ----------------------------------------
`define STATUS_W 6
`define ST_TEST 5
`define ST_IF_HI 4
`define ST_IF_LO 3
`define ST_CFG_HI 2
`define ST_CFG_LO 0
`define STATUS_RESET 6'h00

// ----------------------------------------
// special straps
// ----------------------------------------
`define CFG_NO_AUTOCONFIG 3'h3
`define CFG_W 3
`define CFG_RESET 3'h0

// ----------------------------------------
// reference buffer select codes
// ----------------------------------------
`define REFBUF_OFF 2'h0
`define REFBUF_XTAL 2'h1
`define REFBUF_CLK_IN 2'h2

// ----------------------------------------
// boot sequencing
// ----------------------------------------
`define SYNC_STAGES 2
`define CNT_W 4
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1

`endif

// file: strap_sync.v
// two-stage synchroniser for the strap and reset pins
`include "strap_boot_config_select_regs.vh"
module strap_sync #(
	parameter WIDTH = 1
) (
	input wire sys_clk,
	input wire reset,
	input wire [WIDTH-1:0] din,
	output reg [WIDTH-1:0] dout
);

reg [WIDTH-1:0] stage1;

// ----------------------------------------
// per-bit double flop
// ----------------------------------------
genvar i;
generate
	for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
		always @(posedge sys_clk or posedge reset) begin
			if (reset) begin
				stage1[i] <= 1'b0;
				dout[i] <= 1'b0;
			end else begin
				stage1[i] <= din[i];
				dout[i] <= stage1[i];
			end
		end
	end
endgenerate

endmodule

// file: ref_clock_control.v
// reference buffer and doubler control decode
`include "strap_boot_config_select_regs.vh"
module ref_clock_control (
	input wire sys_clk,
	input wire reset,
	input wire [1:0] ref_buffer_select,
	input wire ref_doubler_en,
	input wire pll_input_doubler_en,
	output reg ref_clk_in_en,
	output reg xtal_driver_en,
	output reg ref_doubler_active,
	output reg pll_doubler_active,
	output reg doubler_conflict
);

// ----------------------------------------
// decode
// ----------------------------------------
always @(posedge sys_clk or posedge reset) begin
	if (reset) begin
		ref_clk_in_en <= 1'b0;
		xtal_driver_en <= 1'b0;
		ref_doubler_active <= 1'b0;
		pll_doubler_active <= 1'b0;
		doubler_conflict <= 1'b0;
	end else begin
		ref_clk_in_en <= (ref_buffer_select == `REFBUF_CLK_IN);
		xtal_driver_en <= (ref_buffer_select == `REFBUF_XTAL);
		// doubler only after an active reference path
		ref_doubler_active <= ref_doubler_en &&
			(ref_buffer_select == `REFBUF_CLK_IN ||
			ref_buffer_select == `REFBUF_XTAL);
		pll_doubler_active <= pll_input_doubler_en;
		// flags the unsupported double doubling
		doubler_conflict <= ref_doubler_en && pll_input_doubler_en;
	end
end

endmodule

// file: strap_boot_config_select_monitor.sv
// assertion checker for the strap decoder
`include "strap_boot_config_select_regs.vh"
module strap_boot_config_select_monitor #(
	parameter INTERNAL_EEPROM = 0
) (
	input wire sys_clk,
	input wire reset,
	input wire reset_in_n,
	input wire [1:0] ref_buffer_select,
	input wire ref_doubler_en,
	input wire [5:0] strap_status_reg,
	input wire [3:0] interface_mode,
	input wire [1:0] boot_source,
	input wire [2:0] config_index,
	input wire autoconfig_en,
	input wire boot_start,
	input wire boot_active,
	input wire [6:0] slave_addr_reg,
	input wire chip_select_oe_n,
	input wire ref_clk_in_en,
	input wire xtal_driver_en,
	input wire ref_doubler_active
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// ----------------
	// decode checks
	// ----------------
	a_latch_holds: assert property (reset_in_n [*6] |=>
		$stable(strap_status_reg) && $stable(config_index))
		else $error("latched straps moved");
	a_cfg_index: assert property (reset_in_n [*6] |->
		config_index == strap_status_reg[2:0]) else $error("bad index");
	a_addr_default: assert property ($changed(strap_status_reg) &&
		!strap_status_reg[4] |-> slave_addr_reg ==
		{5'h1d, strap_status_reg[4:3]}) else $error("bad address");
	a_master_code: assert property (interface_mode == `MODE_SPI_MASTER |->
		strap_status_reg[4:3] == 2'h3 && INTERNAL_EEPROM == 0)
		else $error("bad master mode");
	a_skip_boot: assert property (boot_start |-> autoconfig_en &&
		!(strap_status_reg[5] && strap_status_reg[2:0] == 3'h3))
		else $error("boot when skipped");
	a_cs_drive: assert property (!chip_select_oe_n |-> boot_active &&
		boot_source == `BOOT_EXT_EEPROM) else $error("select driven");
	a_xtal_on: assert property (ref_buffer_select == 2'h1 |=>
		xtal_driver_en && !ref_clk_in_en) else $error("bad xtal");
	a_dbl_follow: assert property (ref_doubler_en && ^ref_buffer_select |=>
		ref_doubler_active) else $error("bad doubler");
endmodule
bind strap_boot_config_select strap_boot_config_select_monitor #(
	.INTERNAL_EEPROM(INTERNAL_EEPROM)) u_mon (.sys_clk, .reset, .reset_in_n,
	.ref_buffer_select, .ref_doubler_en, .strap_status_reg, .interface_mode,
	.boot_source, .config_index, .autoconfig_en, .boot_start, .boot_active,
	.slave_addr_reg, .chip_select_oe_n, .ref_clk_in_en, .xtal_driver_en,
	.ref_doubler_active);

// file: strap_boot_eeprom_model.sv
// boot controller and eeprom stand-in
module strap_boot_eeprom_model (
	input wire sys_clk,
	input wire boot_active,
	input wire [7:0] delay,
	output logic boot_cs_req,
	output logic boot_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] n = 0;
	initial boot_cs_req = 0;
	initial boot_done = 0;
	always @(posedge sys_clk) begin
		boot_cs_req <= boot_active;
		n <= boot_active ? n + 8'h1 : 8'h0;
		boot_done <= boot_active && n == delay;
	end
endmodule

// file: strap_boot_config_select_tb_top.sv
// self-checking bench for the strap decoder
`include "strap_boot_config_select_regs.vh"
module strap_boot_config_select_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, reset = 1, reset_in_n = 0, test_strap = 0;
	logic [1:0] interface_strap = 0, ref_buffer_select = 0;
	logic [2:0] config_select_strap = 0;
	logic slave_addr_wr = 0, ref_doubler_en = 0, pll_input_doubler_en = 0;
	logic [6:0] slave_addr_wdata = 0, slave_addr_reg;
	logic [7:0] delay = 8'h10;
	logic boot_done, boot_cs_req, autoconfig_en, boot_start, boot_active;
	logic chip_select_n, chip_select_oe_n, ref_clk_in_en, xtal_driver_en;
	logic ref_doubler_active, pll_doubler_active, doubler_conflict;
	logic int_cs_n, int_cs_oe_n;
	logic [3:0] int_mode;
	logic [1:0] int_boot;
	logic [6:0] int_addr;
	logic [5:0] strap_status_reg;
	logic [3:0] interface_mode;
	logic [1:0] boot_source;
	logic [2:0] config_index;
	int err_count = 0, n_compared = 0, cycles = 0, seed = 32'hd55791af;
	strap_boot_config_select #(.INTERNAL_EEPROM(0)) dut (.sys_clk, .reset,
		.reset_in_n, .test_strap, .interface_strap, .config_select_strap,
		.slave_addr_wr, .slave_addr_wdata, .boot_done, .boot_cs_req,
		.ref_buffer_select, .ref_doubler_en, .pll_input_doubler_en,
		.strap_status_reg, .interface_mode, .boot_source, .config_index,
		.autoconfig_en, .boot_start, .boot_active, .slave_addr_reg,
		.chip_select_n, .chip_select_oe_n, .ref_clk_in_en, .xtal_driver_en,
		.ref_doubler_active, .pll_doubler_active, .doubler_conflict);
	strap_boot_config_select #(.INTERNAL_EEPROM(1)) dut_int (.sys_clk,
		.reset, .reset_in_n, .test_strap, .interface_strap,
		.config_select_strap, .slave_addr_wr, .slave_addr_wdata,
		.boot_done, .boot_cs_req, .ref_buffer_select, .ref_doubler_en,
		.pll_input_doubler_en, .strap_status_reg(),
		.interface_mode(int_mode), .boot_source(int_boot),
		.config_index(), .autoconfig_en(), .boot_start(),
		.boot_active(), .slave_addr_reg(int_addr),
		.chip_select_n(int_cs_n), .chip_select_oe_n(int_cs_oe_n),
		.ref_clk_in_en(), .xtal_driver_en(), .ref_doubler_active(),
		.pll_doubler_active(), .doubler_conflict());
	strap_boot_eeprom_model u_eeprom (.sys_clk, .boot_active, .delay,
		.boot_cs_req, .boot_done);
	initial forever #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 40000) begin
			err_count++;
			test_done();
		end
	end
	// ----------------
	// helpers
	// ----------------
	task step(input int n);
		repeat (n) @(posedge sys_clk);
		#5;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task test_done;
		if (err_count == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	function logic [3:0] exp_mode(input logic [1:0] c);
		return c == 3 ? `MODE_SPI_MASTER : c == 2 ? `MODE_SPI_SLAVE : `MODE_I2C;
	endfunction
	// latch straps, check decode, run boot, then rewrite the address
	task latch(input logic t, input logic [1:0] c, input logic [2:0] g);
		logic sk;
		logic [6:0] a;
		sk = t && g == 3;
		reset_in_n = 0;
		{test_strap, interface_strap, config_select_strap} = {t, c, g};
		step(4);
		reset_in_n = 1;
		step(4);
		chk(boot_start, !sk);
		step(2);
		{test_strap, interface_strap, config_select_strap} = $random(seed);
		step(2);
		chk(strap_status_reg, {t, c, g});
		chk(config_index, g);
		chk(interface_mode, sk && c == 3 ? 4'h2 : exp_mode(c));
		chk(boot_source, sk ? `BOOT_NONE : c == 3);
		chk(autoconfig_en, !sk);
		if (!c[1]) chk(slave_addr_reg, {5'h1d, c});
		chk({chip_select_oe_n, chip_select_n}, c == 3 && !sk ? 0 : 3);
		chk(int_mode, c == 3 ? `MODE_SPI_SLAVE : `MODE_I2C);
		chk(int_boot, sk ? `BOOT_NONE : `BOOT_INT_EEPROM);
		if (c != 3) chk(int_addr, {5'h1d, c});
		chk({int_cs_oe_n, int_cs_n}, 3);
		for (int i = 0; i < 300 && boot_active; i++) step(1);
		chk({boot_active, chip_select_oe_n}, 1);
		step(1);
		chk(interface_mode, c == 3 ? 4'h2 : exp_mode(c));
		a = $random(seed);
		slave_addr_wdata = a;
		slave_addr_wr = 1;
		step(1);
		slave_addr_wr = 0;
		step(1);
		chk(slave_addr_reg, a);
		chk(int_addr, a);
	endtask
	initial begin
		step(3);
		chk({chip_select_n, chip_select_oe_n, boot_source}, 4'hf);
		chk(slave_addr_reg, `ADDR_A0);
		reset = 0;
		for (int k = 0; k < 40; k++) begin
			delay = 8'(8 + ($random(seed) & 63));
			latch(k < 8 ? 1'b1 : 1'($random(seed)), k[1:0],
				k < 8 ? 3'h3 : k[4:2]);
		end
		for (int k = 0; k < 32; k++) begin
			{ref_buffer_select, ref_doubler_en} = $random(seed);
			pll_input_doubler_en = !ref_doubler_en && 1'($random(seed));
			step(1);
			chk({ref_clk_in_en, xtal_driver_en, ref_doubler_active,
				pll_doubler_active, doubler_conflict},
				{ref_buffer_select == 2, ref_buffer_select == 1,
				ref_doubler_en && ^ref_buffer_select,
				pll_input_doubler_en, 1'b0});
		end
		reset = 1;
		step(2);
		chk(slave_addr_reg, `ADDR_A0);
		reset = 0;
		latch(0, 1, 5);
		test_done();
	end
endmodule
